// [hdl/bpwm_core.sv]
// Purpose: single channel burst pwm for an led or motor driver stage
// Assumes: register port is the byte interface behind the serial slave
// Notes:   output is low during the active part, the sinking-load convention
`timescale 1ns/1ps
`default_nettype none

module bpwm_core
    import bpwm_pkg::*;
#(
    parameter int CLK_HZ = bpwm_pkg::BPWM_CLK_HZ  // reference rate
) (
    input  wire logic       i_ref_clk,                 // 50 MHz clock
    input  wire logic       i_rstn,                    // sync reset, active low
    input  wire logic [7:0] i_reg_addr,                // register address
    input  wire logic       i_reg_wr,                  // write strobe
    input  wire logic       i_reg_rd,                  // read strobe
    input  wire logic [7:0] i_reg_wdata,               // write data
    input  wire logic       i_gen_clock_off,           // clock gate from system ctrl
    output logic      [7:0] o_reg_rdata,               // read data, registered
    output logic            o_pwm_out,                 // modulated pin level
    output logic            o_running,                 // generator active
    output logic            o_port_zero_activity_flag  // sticky burst-done flag
);
    import bpwm_pkg::*;

    logic [7:0]  div_reg_r;      // pwm_prescale_and_burst_unit
    logic [7:0]  ctrl_reg_r;     // pwm_duty_and_run_control, run bit unused
    logic        run_r;
    logic [4:0]  div_cnt_r;
    logic [3:0]  step_r;
    logic [3:0]  duty_cur_r;
    logic [11:0] ms_cnt_r;
    logic [11:0] burst_ms;
    logic        base_tick;
    logic        ms_tick;
    logic        base_tick_raw;  // tick generator output, before the gate
    logic        ms_tick_raw;    // tick generator output, before the gate
    logic        step_tick;
    logic        burst_done;
    logic        wr_div;
    logic        wr_ctrl;
    logic        rd_isr;
    logic [4:0]  div_val;
    logic [2:0]  unit_sel;
    logic [1:0]  count_sel;
    logic [3:0]  duty_val;
    logic        idle_low;

    // ==========================================================
    // field extraction and decode; a gated block takes no writes and answers only status reads
    assign div_val   = div_reg_r[BPWM_DIV_LSB +: 5];
    assign unit_sel  = div_reg_r[BPWM_UNIT_LSB +: 3];
    assign count_sel = ctrl_reg_r[BPWM_COUNT_LSB +: 2];
    assign duty_val  = ctrl_reg_r[BPWM_DUTY_LSB +: 4];
    assign idle_low  = ctrl_reg_r[BPWM_IDLE_BIT];
    assign wr_div    = i_reg_wr && !i_gen_clock_off && (i_reg_addr == BPWM_ADDR_DIV);
    assign wr_ctrl   = i_reg_wr && !i_gen_clock_off && (i_reg_addr == BPWM_ADDR_CTRL);
    assign rd_isr    = i_reg_rd && (i_reg_addr == BPWM_ADDR_ISR);

    // ==========================================================
    // base clock at BPWM_BASE_HZ, a fraction NUM/DEN of the reference clock rate
    bpwm_tick_gen #(
        .NUM (BPWM_BASE_HZ),
        .DEN (CLK_HZ),
        .AW  (27)
    ) u_base_tick (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_hold    (i_gen_clock_off),
        .o_tick    (base_tick_raw)
    );

    // millisecond time base for burst length
    bpwm_tick_gen #(
        .NUM (BPWM_MS_HZ),
        .DEN (CLK_HZ),
        .AW  (27)
    ) u_ms_tick (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_hold    (i_gen_clock_off),
        .o_tick    (ms_tick_raw)
    );

    // a tick launched just before the gate closes must not slip through
    assign base_tick = base_tick_raw && !i_gen_clock_off;
    assign ms_tick   = ms_tick_raw && !i_gen_clock_off;

    // ==========================================================
    // register storage, cleared to zero
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            div_reg_r  <= BPWM_RST_VAL;
            ctrl_reg_r <= BPWM_RST_VAL;
        end
        else
        begin
            if (wr_div)
                div_reg_r <= i_reg_wdata;
            if (wr_ctrl)
                ctrl_reg_r <= i_reg_wdata;
        end
    end

    // ==========================================================
    // prescaler: step every (div+1) base ticks
    assign step_tick = run_r && base_tick && (div_cnt_r == div_val);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn || !run_r)
            div_cnt_r <= '0;
        else if (step_tick)
            div_cnt_r <= '0;
        else if (base_tick)
            div_cnt_r <= div_cnt_r + 5'h01;
    end

    // ==========================================================
    // step counter, sixteen steps per period; duty latched at wrap
    // so a mid-period update cannot chop a pulse
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            step_r     <= '0;
            duty_cur_r <= '0;
        end
        else if (!run_r && !i_gen_clock_off)
        begin
            step_r     <= '0;
            // the starting write carries the duty of the first period
            duty_cur_r <= wr_ctrl ? i_reg_wdata[BPWM_DUTY_LSB +: 4] : duty_val;
        end
        else if (step_tick)
        begin
            step_r <= step_r + 4'h1;
            if (step_r == 4'(BPWM_STEPS - 1))
                duty_cur_r <= duty_val;
        end
    end

    // ==========================================================
    // burst length: unit time doubled per code, times count
    assign burst_ms = 12'(12'(BPWM_BURST_BASE_MS) << unit_sel) * 12'(count_sel);

    assign burst_done = run_r && (count_sel != 2'b00) && ms_tick
                        && (ms_cnt_r >= burst_ms - 12'h001);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn || !run_r)
            ms_cnt_r <= '0;
        else if (ms_tick && count_sel != 2'b00)
            ms_cnt_r <= ms_cnt_r + 12'h001;
    end

    // ==========================================================
    // run state: software start/stop, hardware stop at burst end
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            run_r <= 1'b0;
        else if (wr_ctrl)
            run_r <= i_reg_wdata[BPWM_RUN_BIT];
        else if (burst_done)
            run_r <= 1'b0;
    end

    // ==========================================================
    // activity flag: a set in the read cycle wins over the clear
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            o_port_zero_activity_flag <= 1'b0;
        else if (burst_done)
            o_port_zero_activity_flag <= 1'b1;
        else if (rd_isr)
            o_port_zero_activity_flag <= 1'b0;
    end

    // ==========================================================
    // read data; gated registers read as zero
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            o_reg_rdata <= BPWM_RST_VAL;
        else if (i_reg_rd)
        begin
            o_reg_rdata <= BPWM_RST_VAL;
            if (rd_isr)
                o_reg_rdata[BPWM_FLAG_BIT] <= o_port_zero_activity_flag;
            else if (!i_gen_clock_off && i_reg_addr == BPWM_ADDR_DIV)
                o_reg_rdata <= div_reg_r;
            else if (!i_gen_clock_off && i_reg_addr == BPWM_ADDR_CTRL)
                o_reg_rdata <= {ctrl_reg_r[7:1], run_r};
        end
    end

    // ==========================================================
    // pin: low during the active part; duty comes pre-inverted
    // from the host for sourcing loads
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            o_pwm_out <= 1'b1;
        else if (!run_r)
            o_pwm_out <= ~idle_low;
        else
            o_pwm_out <= ~(step_r <= duty_cur_r);
    end

    assign o_running = run_r;

    // ==========================================================
    // checks
    sequence s_base_gap;
        base_tick ##1 (!base_tick)[*8];
    endsequence

    sequence s_period_end;
        step_tick && step_r == 4'hF;
    endsequence

    a_base_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        base_tick |-> s_base_gap)
        else $error("base tick too frequent");

    a_prescale_match: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        step_tick |-> div_cnt_r == div_val ##1 div_cnt_r == 5'h00)
        else $error("prescaler step mismatch");

    a_period_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_period_end ##1 run_r |-> step_r == 4'h0 && duty_cur_r == $past(duty_val))
        else $error("period wrap or duty latch wrong");

    a_duty_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        run_r && !(step_tick && step_r == 4'hF) ##1 run_r |-> $stable(duty_cur_r))
        else $error("duty changed mid period");

    a_pin_duty: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        run_r ##1 run_r |-> o_pwm_out == ($past(step_r) > $past(duty_cur_r)))
        else $error("pin level disagrees with duty");

    a_idle_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !run_r ##1 !run_r |-> o_pwm_out == !$past(idle_low))
        else $error("idle level wrong");

    a_run_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ctrl |=> run_r == $past(i_reg_wdata[BPWM_RUN_BIT]))
        else $error("run bit write not obeyed");

    a_burst_end: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        burst_done && !wr_ctrl |=> !run_r && o_port_zero_activity_flag)
        else $error("burst end did not stop and flag");

    a_endless_run: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        run_r && count_sel == 2'b00 && !wr_ctrl |-> !burst_done ##1 run_r)
        else $error("endless run ended");

    a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        rd_isr && !burst_done |=> !o_port_zero_activity_flag)
        else $error("status read did not clear flag");

    a_gate_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_gen_clock_off ##1 i_gen_clock_off |-> $stable(step_r) && $stable(div_reg_r))
        else $error("gated generator moved");

endmodule : bpwm_core

`default_nettype wire

// [hdl/bpwm_tick_gen.sv]
// Purpose: fractional rate tick generator
// Assumes: NUM below DEN, both fit the accumulator
// Notes:   phase accumulator keeps the mean rate exact with jitter of one cycle
`timescale 1ns/1ps
`default_nettype none

module bpwm_tick_gen #(
    parameter int NUM = 600_000,     // output rate
    parameter int DEN = 50_000_000,  // clock rate
    parameter int AW  = 27           // accumulator width
) (
    input  wire logic i_ref_clk,     // clock
    input  wire logic i_rstn,        // sync reset, active low
    input  wire logic i_hold,        // freeze while clock is gated
    output logic      o_tick         // one-cycle pulse at NUM/DEN rate
);

    logic [AW-1:0] acc_r;
    logic [AW-1:0] acc_sum;

    assign acc_sum = acc_r + AW'(NUM);

    // ==========================================================
    // accumulator; wrap by DEN marks a tick
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            acc_r  <= '0;
            o_tick <= 1'b0;
        end
        else if (i_hold)
        begin
            o_tick <= 1'b0;
        end
        else if (acc_sum >= AW'(DEN))
        begin
            acc_r  <= acc_sum - AW'(DEN);
            o_tick <= 1'b1;
        end
        else
        begin
            acc_r  <= acc_sum;
            o_tick <= 1'b0;
        end
    end

endmodule : bpwm_tick_gen

`default_nettype wire

// [pkg/bpwm_pkg.sv]
// Purpose: shared constants for the burst pwm led driver
// Assumes: 50 MHz reference clock, 8-bit register port behind the serial slave
// Notes:   offsets, field positions and timing figures live here only
`default_nettype none

package bpwm_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] BPWM_ADDR_DIV  = 8'h50; // pwm_prescale_and_burst_unit
    localparam logic [7:0] BPWM_ADDR_CTRL = 8'h51; // pwm_duty_and_run_control
    localparam logic [7:0] BPWM_ADDR_ISR  = 8'h0A; // shared interrupt status
    localparam logic [7:0] BPWM_RST_VAL   = 8'h00;

    // ==========================================================
    // field positions
    localparam int BPWM_DIV_LSB    = 0;   // prescale [4:0]
    localparam int BPWM_UNIT_LSB   = 5;   // burst_unit_select [7:5]
    localparam int BPWM_RUN_BIT    = 0;   // run
    localparam int BPWM_IDLE_BIT   = 1;   // idle level
    localparam int BPWM_COUNT_LSB  = 2;   // burst_count_select [3:2]
    localparam int BPWM_DUTY_LSB   = 4;   // duty [7:4]
    localparam int BPWM_FLAG_BIT   = 2;   // port_zero_activity_flag in status

    // ==========================================================
    // timing
    localparam int BPWM_CLK_HZ       = 50_000_000;
    localparam int BPWM_BASE_HZ      = 600_000;   // 1/83 of the reference clock
    localparam int BPWM_MS_HZ        = 1_000;     // burst time base
    localparam int BPWM_BURST_BASE_MS = 8;        // code 000
    localparam int BPWM_STEPS        = 16;        // steps per period
    localparam int BPWM_MIN_BASE_GAP = BPWM_CLK_HZ / BPWM_BASE_HZ; // 83, rounded down

endpackage : bpwm_pkg

`default_nettype wire

// [tb/bpwm_load_model.sv]
// Purpose: led or motor driver stage hanging on the pwm pin
// Assumes: one clock, pin sampled on the rising edge
// Notes:   on-time integrator, phase free when read over whole periods
`timescale 1ns/1ps
`default_nettype none

module bpwm_load_model #(
    parameter bit SOURCING = 1'b0      // load wired to ground side, lit on a high pin
) (
    input  wire logic        i_ref_clk,  // clock
    input  wire logic        i_pin,      // pwm pin level
    input  wire logic        i_clear,    // restart integration
    output logic      [15:0] o_on_count  // cycles the load was lit
);
    logic lit;

    // sinking load lights on a low pin; a sourcing one needs inverted duty
    assign lit = SOURCING ? i_pin : ~i_pin;

    // on-time integrator, cleared by the bench before each window
    always_ff @(posedge i_ref_clk)
    begin
        if (i_clear)
            o_on_count <= 16'h0000;
        else if (lit)
            o_on_count <= o_on_count + 16'h0001;
    end
endmodule : bpwm_load_model

`default_nettype wire

// [tb/burst_pwm_led_driver_tb.sv]
// Purpose: self-checking bench for the burst pwm core
// Assumes: core scaled to a 6 MHz notion of the clock to keep runs short
// Notes:   reset and register checks first, then duty table, burst, status and gating cases
`timescale 1ns/1ps
`default_nettype none

module burst_pwm_led_driver_tb;
    import bpwm_pkg::*;
    localparam int CLK_HZ = 6_000_000;             // base tick every 10 clocks
    localparam int TICK   = CLK_HZ / BPWM_BASE_HZ;
    localparam int MS     = CLK_HZ / BPWM_MS_HZ;
    typedef struct {logic [4:0] div; logic [3:0] duty; logic idle; logic [15:0] low;} bpwm_row_s;

    // ==========================================================
    // signals
    logic        ref_clk;
    logic        rstn;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic        gate;
    logic [7:0]  rdata;
    logic        pwm;
    logic        running;
    logic        flag;
    logic        clear;
    logic [15:0] on_cnt;
    int          mismatches;
    int          samples_checked;
    int          n;
    int          win;
    // low cycles over two periods: 2*(duty+1)*(div+1)*TICK
    bpwm_row_s   rows [5] = '{'{5'h00, 4'h0, 1'b0, 16'h0014}, '{5'h01, 4'h7, 1'b0, 16'h0140},
                              '{5'h00, 4'hF, 1'b1, 16'h0140}, '{5'h1F, 4'h3, 1'b0, 16'h0A00},
                              '{5'h02, 4'hA, 1'b1, 16'h0294}};

    bpwm_core #(.CLK_HZ(CLK_HZ)) dut_u (.i_ref_clk(ref_clk), .i_rstn(rstn),
        .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
        .i_gen_clock_off(gate), .o_reg_rdata(rdata), .o_pwm_out(pwm), .o_running(running),
        .o_port_zero_activity_flag(flag));

    bpwm_load_model load_u (.i_ref_clk(ref_clk), .i_pin(pwm), .i_clear(clear),
        .o_on_count(on_cnt));

    // ==========================================================
    // clock and shared tasks
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check

    // strobe held one cycle; the task returns on the edge that takes it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr_reg

    // read data is registered and holds, so one more edge is safe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(nm, {8'h00, exp}, {8'h00, rdata});
    endtask : rd_reg

    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // hang guard, well past the longest sequence
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rstn <= 1'b0;
        reg_addr <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= 8'h00;
        gate <= 1'b0;
        clear <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1;
        check("pin_idle", 16'h0001, {15'h0000, pwm});
        check("running", 16'h0000, {15'h0000, running});
        rd_reg(BPWM_ADDR_DIV, 8'h00, "div_reset");
        rd_reg(BPWM_ADDR_CTRL, 8'h00, "ctrl_reset");
        wr_reg(BPWM_ADDR_DIV, 8'hA5);
        rd_reg(BPWM_ADDR_DIV, 8'hA5, "div_rw");
        rd_reg(8'h33, 8'h00, "unmapped");
        // endless runs: on-time over two whole periods, then stop to idle
        foreach (rows[i])
        begin
            wr_reg(BPWM_ADDR_DIV, {3'b000, rows[i].div});
            wr_reg(BPWM_ADDR_CTRL, {rows[i].duty, 2'b00, rows[i].idle, 1'b1});
            #1;
            check("run_start", 16'h0001, {15'h0000, running});
            @(posedge ref_clk);
            #1;
            check("first_step", 16'h0000, {15'h0000, pwm});
            win = 32 * (rows[i].div + 1) * TICK;
            repeat (win / 2) @(posedge ref_clk);
            clear <= 1'b1;
            @(posedge ref_clk);
            clear <= 1'b0;
            repeat (win) @(posedge ref_clk);
            #1;
            check("on_time", rows[i].low, on_cnt);
            check("endless", 16'h0001, {15'h0000, running});
            rd_reg(BPWM_ADDR_CTRL, {rows[i].duty, 2'b00, rows[i].idle, 1'b1}, "run_rd");
            wr_reg(BPWM_ADDR_CTRL, {rows[i].duty, 2'b00, rows[i].idle, 1'b0});
            repeat (2) @(posedge ref_clk);
            #1;
            check("stop_idle", {15'h0000, ~rows[i].idle}, {15'h0000, pwm});
            check("stopped", 16'h0000, {15'h0000, running});
        end
        check("flag_endless", 16'h0000, {15'h0000, flag});
        // shortest timed burst: 8 ms times one, self-terminating
        wr_reg(BPWM_ADDR_DIV, 8'h00);
        wr_reg(BPWM_ADDR_CTRL, 8'h05);
        #1;
        n = 0;
        while (running === 1'b1 && n < 10 * MS)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("burst_len", 16'h0001, {15'h0000, (n >= 7 * MS - 4 && n <= 8 * MS + 4)});
        @(posedge ref_clk);
        #1;
        check("flag_set", 16'h0001, {15'h0000, flag});
        @(posedge ref_clk);
        #1;
        check("burst_idle", 16'h0001, {15'h0000, pwm});
        rd_reg(BPWM_ADDR_CTRL, 8'h04, "run_after_burst");
        wr_reg(BPWM_ADDR_ISR, 8'h00);
        rd_reg(BPWM_ADDR_ISR, 8'h04, "status_read");
        rd_reg(BPWM_ADDR_ISR, 8'h00, "status_clear");
        // gated generator: registers unreachable, old contents kept
        @(posedge ref_clk);
        gate <= 1'b1;
        wr_reg(BPWM_ADDR_DIV, 8'h3C);
        rd_reg(BPWM_ADDR_DIV, 8'h00, "gated_read");
        @(posedge ref_clk);
        gate <= 1'b0;
        rd_reg(BPWM_ADDR_DIV, 8'h00, "gated_write");
        give_verdict();
    end
endmodule : burst_pwm_led_driver_tb

`default_nettype wire
